// file: hw/eeprom_bus_master.sv
/*
  Two-wire bus master that drives a serial EEPROM through its clock and
  data pins. It makes the bus clock from ref_clk by a divider and takes
  one bus operation at a time from a plain command port.
  Assumes pull-ups on both lines and that the user sequences the ops.
*/
`timescale 1ns/100ps
`include "eeprom_master_params.svh"

// Operation
// R1: Device samples data on clock rise, drives changes on clock fall.
// R2: Every byte travels most significant bit first, one bit per clock.
// R3: Each byte takes nine clocks: eight data bits plus acknowledge.
// R4: Data changes only while clock low; change while high is Start/Stop.
// R5: Start is data falling while clock high; precedes every command.
// R6: Device detects data rising while clock high as Stop.
// R7: Stop ending a write command launches the internal write cycle.
// R8: Master releases data on ninth clock; device holds it low to acknowledge.
// R9: Device enters standby after power-up, read Stop, or internal operation.
// R10: Recovery: Start, nine clocks, Start, then Stop.
// R11: Device ignores the bus until its power-on reset releases.
// R12: Brown-out resets the device; it stays silent until reset releases.
// R13: Hardware protect input high blocks array and identification page writes.
// R14: Soft protect bit at one blocks array and identification page writes.
// R15: Address byte: type in bits 7-4, strap bit 3, rw in bit 0.
// R16: Type 1010 selects the array; 1011 selects the special functions.
// R17: Device answers only when the strap bit matches its strap input.
// R18: Address byte last bit: one means read, zero means write.
// R19: Device acknowledges a matching address, not a mismatching one.
// R20: Address bits 2 and 1 carry the top two array address bits.
// R21: Special word address bits 7:6 pick function; bits 3:0 index bytes.
// R22: Device acknowledges the word address byte after its address byte.
// R23: Master decides how many bytes pass between Start and Stop.
// R24: Under protection device acknowledges addresses but not data bytes.
// R25: Write starts only if Stop comes in tenth clock after data.
// R26: Device does not acknowledge its address during a write cycle.
// R27: Device only pulls data low or releases it.
// R28: Write cycle is a busy interval during which inputs are ignored.
module eeprom_bus_master
  import eeprom_master_pkg::*;
#(
  parameter int QUARTER = `QUARTER_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input wire eeprom_master_pkg::op_e cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  input wire logic cmd_special,
  input wire logic cmd_chip_sel,
  input wire logic [1:0] cmd_addr_hi,
  input wire logic cmd_rw,
  input wire logic [1:0] cmd_fn,
  output logic cmd_ready,
  // Answer port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  output logic bus_active,
  // Bus pins
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import eeprom_master_pkg::*;

  localparam int QW = $clog2(QUARTER + 1);

  // ****************************************************
  // Signals
  // ****************************************************
  st_e st_reg;
  logic [1:0] phase_reg;
  logic [QW-1:0] qcnt_reg;
  logic [3:0] bit_idx_reg;
  logic [8:0] tx_reg;
  logic [8:0] rx_reg;
  logic rd_reg;
  logic rec_reg;
  logic [1:0] rec_step_reg;
  logic sda_s;
  logic in_bits;
  logic tick;
  logic step_end;
  logic accept;
  logic scl_oe_next;
  logic sda_oe_next;

  assign in_bits = (st_reg == ST_BITS);
  assign tick = (qcnt_reg == '0);
  assign step_end = (st_reg != ST_IDLE) && tick && (phase_reg == 2'h3);
  assign accept = cmd_valid && cmd_ready && (st_reg == ST_IDLE);

  // ****************************************************
  // Byte builders
  // ****************************************************
  function automatic logic [7:0] addr_byte(input logic special,
                                           input logic cs,
                                           input logic [1:0] hi,
                                           input logic rw);
    logic [7:0] b;
    b = '0;
    b[`DA_TYPE_MSB:`DA_TYPE_LSB] = special ? `TYPE_SPECIAL : `TYPE_ARRAY; // R16
    b[`DA_CS_BIT] = cs; // R15
    b[`DA_HI_MSB:`DA_HI_LSB] = hi; // R20
    b[`DA_RW_BIT] = rw; // R18
    return b;
  endfunction : addr_byte

  function automatic logic [7:0] func_byte(input logic [1:0] fn,
                                           input logic [3:0] idx);
    logic [7:0] w;
    w = '0;
    w[`WA_FN_MSB:`WA_FN_LSB] = fn; // R21
    w[`WA_IDX_MSB:0] = idx; // R21
    return w;
  endfunction : func_byte

  // ****************************************************
  // Data line synchroniser
  // ****************************************************
  two_flop_sync #(
    .WIDTH(1)
  ) u_sda_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(sda_i),
    .sync_out(sda_s)
  );

  // ****************************************************
  // Quarter-period timebase
  // ****************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      qcnt_reg <= '0;
      phase_reg <= 2'h0;
    end else if (accept || st_reg == ST_IDLE) begin
      qcnt_reg <= QW'(QUARTER - 1);
      phase_reg <= 2'h0;
    end else if (tick) begin
      qcnt_reg <= QW'(QUARTER - 1);
      phase_reg <= phase_reg + 2'h1;
    end else begin
      qcnt_reg <= qcnt_reg - QW'(1);
    end
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ST_IDLE;
      bit_idx_reg <= 4'h0;
      tx_reg <= `RST_FRAME;
      rd_reg <= 1'b0;
      rec_reg <= 1'b0;
      rec_step_reg <= 2'h0;
      cmd_ready <= 1'b0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          cmd_ready <= !accept;
          bit_idx_reg <= 4'h0;
          if (accept) begin
            case (cmd_op)
              OP_START: st_reg <= ST_START; // R5
              OP_STOP: st_reg <= ST_STOP;
              OP_WRITE: begin // R23
                tx_reg <= {cmd_data, 1'b1}; // R8
                rd_reg <= 1'b0;
                st_reg <= ST_BITS;
              end
              OP_ADDR: begin
                tx_reg <= {addr_byte(cmd_special, cmd_chip_sel,
                                     cmd_addr_hi, cmd_rw), 1'b1}; // R15
                rd_reg <= 1'b0;
                st_reg <= ST_BITS;
              end
              OP_FUNC: begin
                tx_reg <= {func_byte(cmd_fn, cmd_data[3:0]), 1'b1};
                rd_reg <= 1'b0;
                st_reg <= ST_BITS;
              end
              OP_READ: begin
                tx_reg <= {8'hff, cmd_nack};
                rd_reg <= 1'b1;
                st_reg <= ST_BITS;
              end
              OP_RECOVER: begin
                rec_reg <= 1'b1; // R10
                rec_step_reg <= 2'h0;
                st_reg <= ST_START;
              end
              default: st_reg <= ST_IDLE;
            endcase
          end
        end
        ST_BITS: begin
          if (step_end) begin
            tx_reg <= {tx_reg[7:0], 1'b1}; // R2
            if (bit_idx_reg != `LAST_BIT_IDX) begin
              bit_idx_reg <= bit_idx_reg + 4'h1; // R3
            end else if (rec_reg) begin
              rec_step_reg <= 2'h2;
              st_reg <= ST_START; // R10
            end else begin
              st_reg <= ST_IDLE;
              cmd_ready <= 1'b1;
            end
          end
        end
        ST_START: begin
          if (step_end) begin
            if (rec_reg && rec_step_reg == 2'h0) begin
              rec_step_reg <= 2'h1;
              tx_reg <= `RST_FRAME; // R10
              rd_reg <= 1'b0;
              bit_idx_reg <= 4'h0;
              st_reg <= ST_BITS;
            end else if (rec_reg) begin
              rec_step_reg <= 2'h3;
              st_reg <= ST_STOP; // R10
            end else begin
              st_reg <= ST_IDLE;
              cmd_ready <= 1'b1;
            end
          end
        end
        ST_STOP: begin
          if (step_end) begin
            rec_reg <= 1'b0;
            rec_step_reg <= 2'h0;
            st_reg <= ST_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Receive shifter and answers
  // ****************************************************
  // Sample a quarter period after the clock rise, well clear of the
  // synchroniser delay and of any slave hold time.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_reg <= '0;
    end else if (in_bits && tick && phase_reg == 2'h1) begin
      rx_reg <= {rx_reg[7:0], sda_s}; // R1
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end else begin
      rsp_valid <= step_end && !rec_reg &&
                   (!in_bits || bit_idx_reg == `LAST_BIT_IDX) ||
                   step_end && rec_reg && st_reg == ST_STOP;
      if (step_end && in_bits && bit_idx_reg == `LAST_BIT_IDX) begin
        rsp_data <= rx_reg[8:1];
        rsp_ack <= !rx_reg[0]; // R8
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_active <= 1'b0;
    end else if (step_end && st_reg == ST_START) begin
      bus_active <= 1'b1;
    end else if (step_end && st_reg == ST_STOP) begin
      bus_active <= 1'b0;
    end
  end

  // ****************************************************
  // Pin drive
  // ****************************************************
  // Both lines are only ever pulled low; a released line is high by
  // pull-up, so a slave may hold the data line low at any time.
  always_comb begin
    scl_oe_next = scl_oe;
    sda_oe_next = sda_oe;
    case (st_reg)
      ST_START: begin
        case (phase_reg)
          2'h0: sda_oe_next = 1'b0;
          2'h1: scl_oe_next = 1'b0;
          2'h2: sda_oe_next = 1'b1; // R5
          default: scl_oe_next = 1'b1;
        endcase
      end
      ST_STOP: begin
        case (phase_reg)
          2'h0: sda_oe_next = 1'b1;
          2'h1: scl_oe_next = 1'b0;
          2'h2: sda_oe_next = 1'b0; // R6
          default: scl_oe_next = 1'b0;
        endcase
      end
      ST_BITS: begin
        case (phase_reg)
          2'h0: sda_oe_next = !tx_reg[8]; // R4
          2'h1: scl_oe_next = 1'b0;
          2'h2: scl_oe_next = 1'b0;
          default: scl_oe_next = 1'b1;
        endcase
      end
      default: begin
        scl_oe_next = scl_oe;
        sda_oe_next = sda_oe;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_oe <= scl_oe_next;
      sda_oe <= sda_oe_next;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence rec_begin;
    st_reg == ST_START && rec_reg && rec_step_reg == 2'h0;
  endsequence

  sequence rec_released_bits;
    in_bits && rec_reg && phase_reg != 2'h0;
  endsequence

  sda_stable_a: assert property ( // R4
    in_bits && !scl_oe && $past(!scl_oe) |-> $stable(sda_oe))
    else $error("data moved while clock high inside a byte");

  start_edge_a: assert property ( // R5
    $rose(sda_oe) && !scl_oe |-> st_reg == ST_START)
    else $error("data fell with clock high outside a start");

  stop_edge_a: assert property ( // R4
    $fell(sda_oe) && !scl_oe |-> st_reg == ST_STOP)
    else $error("data rose with clock high outside a stop");

  nine_bits_a: assert property ( // R3
    $fell(in_bits) |-> $past(bit_idx_reg) == `LAST_BIT_IDX)
    else $error("byte did not last nine clocks");

  msb_first_a: assert property ( // R2
    in_bits && phase_reg == 2'h1 |-> sda_oe == !tx_reg[8])
    else $error("driven bit is not the top of the shifter");

  ack_release_a: assert property ( // R8
    in_bits && !rd_reg && bit_idx_reg == `LAST_BIT_IDX &&
    phase_reg != 2'h0 |-> !sda_oe)
    else $error("master held data during slave acknowledge");

  recover_start_a: assert property ( // R10
    $rose(rec_reg) |-> rec_begin)
    else $error("recovery did not open with a start");

  recover_clocks_a: assert property ( // R10
    rec_released_bits |-> !sda_oe)
    else $error("data driven during recovery clocks");

  rw_bit_a: assert property ( // R18
    accept && cmd_op == OP_ADDR |=> tx_reg[1] == $past(cmd_rw))
    else $error("direction bit not in address byte bit 0");

  type_field_a: assert property ( // R15
    accept && cmd_op == OP_ADDR |=> tx_reg[8:5] ==
    ($past(cmd_special) ? `TYPE_SPECIAL : `TYPE_ARRAY))
    else $error("type identifier wrong in address byte");

  ready_idle_a: assert property (
    cmd_ready |-> st_reg == ST_IDLE)
    else $error("ready raised while busy");

endmodule : eeprom_bus_master

// file: hw/eeprom_master_params.svh
/*
  Timing counts, byte field positions and code values for the two-wire
  EEPROM bus master. Assumes a single reference clock whose period is
  given below.
*/
`ifndef EEPROM_MASTER_PARAMS_SVH
`define EEPROM_MASTER_PARAMS_SVH

// ****************************************************
// Timing
// ****************************************************
`define REF_CLK_PERIOD_NS 100
`define SCL_PERIOD_NS 10000
`define QUARTER_CYCLES ((`SCL_PERIOD_NS / `REF_CLK_PERIOD_NS) / 4)

// ****************************************************
// Byte framing
// ****************************************************
`define LAST_BIT_IDX 4'h8
`define RST_FRAME 9'h1ff

// ****************************************************
// Device address byte
// ****************************************************
`define TYPE_ARRAY 4'ha
`define TYPE_SPECIAL 4'hb
`define DA_TYPE_MSB 7
`define DA_TYPE_LSB 4
`define DA_CS_BIT 3
`define DA_HI_MSB 2
`define DA_HI_LSB 1
`define DA_RW_BIT 0

// ****************************************************
// Word address byte under the special type
// ****************************************************
`define WA_FN_MSB 7
`define WA_FN_LSB 6
`define WA_IDX_MSB 3
`define FN_IDENTIFICATION_PAGE 2'h0
`define FN_LOCK 2'h1
`define FN_UNIQUE_ID 2'h2
`define FN_SOFT_PROTECT 2'h3

`endif

// file: hw/eeprom_master_pkg.sv
/*
  Types shared by the EEPROM bus master and its user.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package eeprom_master_pkg;

  typedef enum logic [2:0] {
    OP_START,
    OP_STOP,
    OP_WRITE,
    OP_READ,
    OP_ADDR,
    OP_FUNC,
    OP_RECOVER
  } op_e;

  typedef enum {
    ST_IDLE,
    ST_START,
    ST_STOP,
    ST_BITS
  } st_e;

endpackage : eeprom_master_pkg

// file: hw/two_flop_sync.sv
/*
  Two flip-flop synchroniser, one chain per bit.
  Assumes the inputs are asynchronous levels.
*/
`timescale 1ns/100ps

module two_flop_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        meta_reg[i] <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta_reg[i] <= async_in[i];
        sync_out[i] <= meta_reg[i];
      end
    end
  end

endmodule : two_flop_sync

// file: sim/eeprom_device_model.sv
/*
  Behavioural serial EEPROM seen from its two-wire pins.
  Assumes resolved, pulled-up levels on scl and sda.
*/
`timescale 1ns/100ps

module eeprom_device_model #(
  parameter int BUSY_NS = 60000
) (
  // Bus levels
  input wire logic scl,
  input wire logic sda,
  // Straps and supply
  input wire logic chip_select_strap,
  input wire logic write_protect,
  input wire logic power_good,
  // Pull-down on data
  output logic sda_pull
);
  logic [7:0] mem [0:1023];
  logic [7:0] sh, txb;
  logic [9:0] addr;
  logic [1:0] fn;
  logic [18:0] pend [$];
  logic live = 0, rd = 0, spec = 0, ok, busy = 0, soft_protect_bit = 0;
  int bitn = 0, byten = 0;

  initial begin
    sda_pull = 0;
    foreach (mem[i]) mem[i] = 8'hff;
  end

  // ****
  // Framing
  // ****
  always @(negedge sda) if (scl && power_good && !busy) begin
    live = 1;
    bitn = 0;
    byten = 0;
    pend.delete();
  end

  // Writes land only on a Stop one clock after an acknowledged data byte
  always @(posedge sda) if (scl) begin
    if (live && !rd && bitn == 1 && pend.size() > 0) begin
      foreach (pend[i]) if (pend[i][18]) soft_protect_bit = pend[i][0];
        else mem[pend[i][17:8]] = pend[i][7:0];
      busy = 1;
    end
    live = 0;
    sda_pull = 0;
  end

  always @(posedge busy) #BUSY_NS busy = 0;

  always @(negedge power_good) begin
    live = 0;
    sda_pull = 0;
  end

  // ****
  // Bits
  // ****
  always @(posedge scl) if (live) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (rd && byten > 0 && sda) live = 0;
    bitn = bitn + 1;
  end

  // Only pulled low or let go, and pulled low only just after scl falls
  always @(negedge scl) if (live) begin
    if (bitn == 9) begin
      bitn = 0;
      byten = byten + 1;
      txb = (spec && fn == 2'h3) ? {7'h0, soft_protect_bit} : mem[addr];
      if (rd) addr = addr + 10'h1;
    end
    if (bitn < 8) sda_pull = rd && byten > 0 && !txb[7 - bitn];
    else begin
      ok = 0;
      if (byten == 0) begin
        ok = sh[7:5] == 3'h5 && sh[3] == chip_select_strap;
        live = ok;
        spec = sh[4];
        rd = sh[0];
        if (!sh[4]) addr[9:8] = sh[2:1];
      end else if (!rd && byten == 1) begin
        ok = 1;
        fn = sh[7:6];
        addr[7:0] = sh;
      end else if (!rd) begin
        ok = !write_protect && !(spec && fn == 2'h2) &&
          (!soft_protect_bit || spec && fn == 2'h3);
        if (ok && (!spec || fn == 2'h3)) pend.push_back({spec, addr, sh});
        if (!spec) addr[3:0] = addr[3:0] + 4'h1;
      end
      sda_pull = ok;
    end
  end
endmodule : eeprom_device_model

// file: sim/eeprom_bus_master_bench.sv
/*
  Self-checking bench: bus master driving the device model.
  Assumes QUARTER of 4 and pull-ups on both lines.
*/
`timescale 1ns/100ps

module eeprom_bus_master_bench;
  import eeprom_master_pkg::*;
  logic ref_clk = 0, sys_rst = 1, cmd_valid = 0, cmd_nack = 0;
  logic cmd_special = 0, cmd_chip_sel = 1, cmd_rw = 0;
  logic [1:0] cmd_addr_hi = 2'h0, cmd_fn = 2'h0;
  logic [7:0] cmd_data = 8'h00;
  op_e cmd_op = OP_START;
  logic cmd_ready, rsp_valid, rsp_ack, bus_active, scl_oe, sda_oe, dev_pull;
  logic [7:0] rsp_data;
  logic scl_out, sda_out;
  logic write_protect = 0, power_good = 0, scl_line, sda_line;
  int n_fail = 0, compares = 0, cycles = 0;

  // ****
  // Wiring
  // ****
  assign scl_line = !scl_oe;
  assign sda_line = !(sda_oe || dev_pull);

  eeprom_bus_master #(.QUARTER(4)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .cmd_special(cmd_special), .cmd_chip_sel(cmd_chip_sel),
    .cmd_addr_hi(cmd_addr_hi), .cmd_rw(cmd_rw), .cmd_fn(cmd_fn),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ack(rsp_ack), .bus_active(bus_active), .scl_o(scl_out),
    .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_out), .sda_oe(sda_oe));

  eeprom_device_model #(.BUSY_NS(60000)) dev_u (
    .scl(scl_line), .sda(sda_line), .chip_select_strap(1'b1),
    .write_protect(write_protect), .power_good(power_good),
    .sda_pull(dev_pull));

  initial forever #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  // ****
  // Tasks
  // ****
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk_ack(input string what, input logic exp);
    compares = compares + 1;
    if (rsp_ack !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %s expected %b seen %b", what, exp, rsp_ack);
    end
  endtask : chk_ack

  task automatic chk_byte(input string what, input logic [7:0] exp, seen);
    compares = compares + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_byte

  // One command, held until taken, then waited to its completion pulse
  task automatic op(input op_e o, input logic [7:0] d = 8'h00);
    int n;
    n = 0;
    cmd_op <= o;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n = n + 1;
    end while (rsp_valid !== 1'b1 && n < 900);
    if (n >= 900) n_fail = n_fail + 1;
  endtask : op

  task automatic sel(input logic spc, rw, input logic [1:0] hi = 2'h2,
                     input logic cs = 1'b1);
    cmd_special <= spc;
    cmd_rw <= rw;
    cmd_addr_hi <= hi;
    cmd_chip_sel <= cs;
    op(OP_START);
    op(OP_ADDR);
  endtask : sel

  task automatic word(input logic spc, input logic [7:0] a);
    cmd_fn <= a[7:6];
    op(spc ? OP_FUNC : OP_WRITE, a);
  endtask : word

  task automatic wr(input logic spc, input logic [7:0] a, d, input logic ex);
    sel(spc, 1'b0);
    chk_ack("address", 1'b1);
    word(spc, a);
    chk_ack("word address", 1'b1);
    op(OP_WRITE, d);
    chk_ack("data", ex);
    op(OP_STOP);
  endtask : wr

  task automatic rd(input logic spc, input logic [1:0] hi,
                    input logic [7:0] a, exp);
    sel(spc, 1'b0, hi);
    word(spc, a);
    sel(spc, 1'b1, hi);
    cmd_nack <= 1'b1;
    op(OP_READ);
    chk_byte("read", exp, rsp_data);
    op(OP_STOP);
  endtask : rd

  // Polls the device address until it is acknowledged again
  task automatic poll(input logic first);
    int k;
    k = 0;
    sel(1'b0, 1'b0);
    op(OP_STOP);
    chk_ack("first poll", first);
    while (rsp_ack !== 1'b1 && k < 20) begin
      sel(1'b0, 1'b0);
      op(OP_STOP);
      k = k + 1;
    end
    chk_ack("poll", 1'b1);
  endtask : poll

  // ****
  // Sequence
  // ****
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sel(1'b0, 1'b0);
    op(OP_STOP);
    chk_ack("no supply", 1'b0);
    chk_byte("idle", 8'h03, {5'h0, bus_active, scl_line, sda_line});
    power_good <= 1'b1;
    sel(1'b0, 1'b0, 2'h2, 1'b0);
    op(OP_STOP);
    chk_ack("other chip", 1'b0);
    sel(1'b0, 1'b0);
    chk_byte("active", 8'h01, {7'h0, bus_active});
    op(OP_WRITE, 8'h35);
    op(OP_WRITE, 8'hc3);
    op(OP_WRITE, 8'h5a);
    chk_ack("second data", 1'b1);
    op(OP_STOP);
    poll(1'b0);
    rd(1'b0, 2'h2, 8'h36, 8'h5a);
    rd(1'b0, 2'h1, 8'h35, 8'hff);
    sel(1'b0, 1'b0);
    op(OP_WRITE, 8'h35);
    op(OP_WRITE, 8'h11);
    sel(1'b0, 1'b0);
    op(OP_STOP);
    poll(1'b1);
    rd(1'b0, 2'h2, 8'h35, 8'hc3);
    wr(1'b1, 8'hc0, 8'h01, 1'b1);
    poll(1'b0);
    wr(1'b0, 8'h35, 8'h77, 1'b0);
    poll(1'b1);
    rd(1'b1, 2'h2, 8'hc0, 8'h01);
    write_protect <= 1'b1;
    wr(1'b1, 8'hc0, 8'h00, 1'b0);
    write_protect <= 1'b0;
    // Protect bit is still set here: only the protect bit takes a write
    for (int f = 0; f < 4; f++) begin
      wr(1'b1, {f[1:0], 6'h00}, 8'h00, f == 3);
    end
    poll(1'b0);
    wr(1'b0, 8'h35, 8'h77, 1'b1);
    poll(1'b0);
    rd(1'b0, 2'h2, 8'h35, 8'h77);
    power_good <= 1'b0;
    sel(1'b0, 1'b0);
    op(OP_STOP);
    chk_ack("brown-out", 1'b0);
    power_good <= 1'b1;
    // Acked burst read leaves the device driving the next byte
    sel(1'b0, 1'b0);
    op(OP_WRITE, 8'h35);
    sel(1'b0, 1'b1);
    cmd_nack <= 1'b0;
    op(OP_READ);
    chk_byte("burst", 8'h77, rsp_data);
    op(OP_RECOVER);
    chk_byte("freed", 8'h03, {6'h0, scl_line, sda_line});
    chk_byte("pin level", 8'h00, {6'h0, scl_out, sda_out});
    poll(1'b1);
    final_report();
  end
endmodule : eeprom_bus_master_bench
